// File: src/oled_power_reset_sequencer.sv
// display driver reset defaults and panel supply settle tracking
// assumes inputs synchronous to I_CLK_SYS; host keeps supply order
`timescale 1ns/1ns
`include "oled_seq_map.svh"
module oled_power_reset_sequencer
  import oled_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_CHIP_INIT_LOW_N,
  input wire logic I_PANEL_HIGH_VOLTAGE_SUPPLY,
  input wire logic i_cmd_display_on,
  input wire logic i_cmd_display_off,
  input wire logic i_cmd_contrast,
  input wire logic [7:0] i_contrast_val,
  input wire logic i_cmd_start_line,
  input wire logic [6:0] i_start_line_val,
  input wire logic i_cmd_col_addr,
  input wire logic [6:0] i_col_addr_val,
  input wire logic i_cmd_remap,
  input wire logic i_seg_remap_val,
  input wire logic i_com_scan_val,
  input wire logic i_cmd_mode,
  input wire logic [1:0] i_mode_val,
  output logic o_display_on,
  output logic [1:0] o_geom_mode,
  output logic o_seg_remap,
  output logic o_com_reverse,
  output logic [6:0] o_start_line,
  output logic [6:0] o_col_addr,
  output logic [7:0] o_contrast,
  output logic o_panel_settled,
  output logic o_panel_discharged
);
  // the chip reset pin acts as a second, synchronous reset source for the display registers; settle tracking ignores it
  logic init_active;
  assign init_active = !I_CHIP_INIT_LOW_N;

  logic [31:0] settle_cnt_reg;
  pwr_state_t state_reg;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_display_on <= 1'b0;
    end else if (init_active) begin
      o_display_on <= 1'b0;
    end else if (i_cmd_display_off) begin
      o_display_on <= 1'b0;
    end else if (i_cmd_display_on) begin
      o_display_on <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_geom_mode <= MODE_480X128;
    end else if (init_active) begin
      o_geom_mode <= MODE_480X128;
    end else if (i_cmd_mode) begin
      o_geom_mode <= i_mode_val;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_seg_remap <= `SEG_MAP_NORMAL;
      o_com_reverse <= `COM_SCAN_NORMAL;
    end else if (init_active) begin
      o_seg_remap <= `SEG_MAP_NORMAL;
      o_com_reverse <= `COM_SCAN_NORMAL;
    end else if (i_cmd_remap) begin
      o_seg_remap <= i_seg_remap_val;
      o_com_reverse <= i_com_scan_val;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_start_line <= `START_LINE_RESET;
    end else if (init_active) begin
      o_start_line <= `START_LINE_RESET;
    end else if (i_cmd_start_line) begin
      o_start_line <= i_start_line_val;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_col_addr <= `COL_ADDR_RESET;
    end else if (init_active) begin
      o_col_addr <= `COL_ADDR_RESET;
    end else if (i_cmd_col_addr) begin
      o_col_addr <= i_col_addr_val;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_contrast <= `CONTRAST_RESET;
    end else if (init_active) begin
      o_contrast <= `CONTRAST_RESET;
    end else if (i_cmd_contrast) begin
      o_contrast <= i_contrast_val;
    end
  end

  // settle tracking only reports; the host still owns the 100 ms waits
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_OFF;
      settle_cnt_reg <= 32'h0;
      o_panel_settled <= 1'b0;
      o_panel_discharged <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_OFF: begin
          if (I_PANEL_HIGH_VOLTAGE_SUPPLY) begin
            state_reg <= ST_ON;
            settle_cnt_reg <= 32'h0;
            o_panel_discharged <= 1'b0;
          end
        end
        ST_ON: begin
          if (!I_PANEL_HIGH_VOLTAGE_SUPPLY) begin
            state_reg <= ST_DWN;
            settle_cnt_reg <= 32'h0;
            o_panel_settled <= 1'b0;
          end else if (settle_cnt_reg >= 32'(SETTLE_CYCLES - 1)) begin
            o_panel_settled <= 1'b1;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
          end
        end
        ST_DWN: begin
          if (I_PANEL_HIGH_VOLTAGE_SUPPLY) begin
            state_reg <= ST_ON;
            settle_cnt_reg <= 32'h0;
          end else if (settle_cnt_reg >= 32'(SETTLE_CYCLES - 1)) begin
            state_reg <= ST_DONE;
            o_panel_discharged <= 1'b1;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
          end
        end
        ST_DONE: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  a_init_display_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active |=> !o_display_on) else $error("display not off under chip init");
  a_init_geom_mode: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active |=> o_geom_mode == MODE_480X128) else $error("mode not default");
  a_init_mapping: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active |=> !o_seg_remap) else $error("segment map not normal");
  a_init_start_line: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active |=> o_start_line == 7'h00) else $error("start line not zero");
  a_init_col_addr: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active |=> o_col_addr == 7'h00) else $error("column counter not zero");
  a_init_com_scan: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> !o_com_reverse) else $error("com scan reversed");
  a_init_contrast: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $fell(I_CHIP_INIT_LOW_N) |=> o_contrast == 8'h7f) else $error("contrast not 7f");
  a_settle_not_early: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $rose(I_PANEL_HIGH_VOLTAGE_SUPPLY) |=> !o_panel_settled) else $error("settled too early");
  a_discharge_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $fell(I_PANEL_HIGH_VOLTAGE_SUPPLY) |=> !o_panel_settled) else $error("settled after supply off");
  // load, hold and supply settle checks: init must keep every default while low, commands must land one edge later
  a_off_wins: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    i_cmd_display_off |=> !o_display_on)
    else $error("display off command not honoured");
  a_on_accept: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !init_active && i_cmd_display_on && !i_cmd_display_off |=> o_display_on)
    else $error("display on command lost");
  a_init_contrast_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> o_contrast == 8'h7f)
    else $error("contrast changed under chip init");
  a_init_seg_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> !o_seg_remap)
    else $error("segment map changed under chip init");
  a_init_start_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> o_start_line == 7'h00)
    else $error("start line changed under chip init");
  a_init_col_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> o_col_addr == 7'h00)
    else $error("column counter changed under chip init");
  a_init_mode_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    init_active ##1 init_active |-> o_geom_mode == MODE_480X128)
    else $error("mode changed under chip init");
  a_contrast_load: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !init_active && i_cmd_contrast |=> o_contrast == $past(i_contrast_val))
    else $error("contrast load lost");
  a_remap_load: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !init_active && i_cmd_remap |=> o_seg_remap == $past(i_seg_remap_val) && o_com_reverse == $past(i_com_scan_val))
    else $error("mapping load lost");
  a_start_load: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !init_active && i_cmd_start_line |=> o_start_line == $past(i_start_line_val))
    else $error("start line load lost");
  a_settle_count: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $rose(o_panel_settled) |-> state_reg == ST_ON && settle_cnt_reg == 32'(SETTLE_CYCLES - 1))
    else $error("settled before full count");
  a_settle_only_on: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    o_panel_settled |-> state_reg == ST_ON)
    else $error("settled outside supply on");
  a_discharge_done: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    $rose(o_panel_discharged) |-> state_reg == ST_DONE)
    else $error("discharged before full count");
  a_discharge_low_on: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    state_reg == ST_ON |-> !o_panel_discharged)
    else $error("discharged while supply on");
endmodule

// File: src/oled_seq_map.svh
// offsets-free constant map for the display reset and power sequencer
// assumes inclusion by the top module only
`ifndef OLED_SEQ_MAP_SVH
`define OLED_SEQ_MAP_SVH
`define CONTRAST_RESET 8'h7f
`define START_LINE_RESET 7'h00
`define COL_ADDR_RESET 7'h00
`define SEG_MAP_NORMAL 1'b0
`define COM_SCAN_NORMAL 1'b0
`define CLK_MHZ 250
`define SETTLE_MS 100
`define SETTLE_CYCLES (`SETTLE_MS * 1000 * `CLK_MHZ)
`endif

// File: src/oled_seq_pkg.sv
// types shared by the display reset and power sequencer
// assumes a single clock domain
package oled_seq_pkg;
  typedef enum logic [1:0] {
    MODE_480X128 = 2'h0,
    MODE_ALT = 2'h1
  } geom_mode_t;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ON = 4'h2,
    ST_DWN = 4'h4,
    ST_DONE = 4'h8
  } pwr_state_t;
endpackage

// File: sim/oled_host_model.sv
// host model: orders supplies, chip init and display commands
// assumes sequencer status flags on the same clock
`timescale 1ns/1ns
module oled_host_model (
  input wire logic i_clk,
  input wire logic i_settled,
  input wire logic i_discharged,
  output logic o_init_n,
  output logic o_supply,
  output logic o_on,
  output logic o_off
);
  initial begin
    o_init_n = 1'b0;
    o_supply = 1'b0;
    o_on = 1'b0;
    o_off = 1'b0;
  end
  task automatic cmd(input logic on);
    @(posedge i_clk);
    o_on <= on;
    o_off <= !on;
    @(posedge i_clk);
    o_on <= 1'b0;
    o_off <= 1'b0;
  endtask
  task automatic set_init(input logic v);
    @(posedge i_clk);
    o_init_n <= v;
  endtask
  // waits are bounded so a stuck flag shows up as ok low
  task automatic up(output logic ok);
    set_init(1'b1);
    cmd(1'b0);
    @(posedge i_clk);
    o_supply <= 1'b1;
    for (int i = 0; i < 100 && i_settled !== 1'b1; i++) @(posedge i_clk) #1;
    ok = i_settled;
    cmd(1'b1);
  endtask
  task automatic down(output logic ok);
    cmd(1'b0);
    @(posedge i_clk);
    o_supply <= 1'b0;
    @(posedge i_clk) #1;
    for (int i = 0; i < 100 && i_discharged !== 1'b1; i++) @(posedge i_clk) #1;
    ok = i_discharged;
  endtask
endmodule

// File: sim/oled_power_reset_sequencer_tb.sv
// self-checking bench for the display reset and power sequencer
// assumes a host model drives supply, init pin and on/off commands
`timescale 1ns/1ns
module oled_power_reset_sequencer_tb;
  import oled_seq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, init_n, sup, on, off, ok;
  logic cc = 0, cs = 0, ca = 0, cr = 0, cm = 0, seg = 0, com = 0;
  logic [7:0] ctr = 8'h00;
  logic [6:0] sl = 7'h00;
  logic [1:0] md = 2'h0;
  logic dsp, rmp, rev, stl, dis;
  logic [1:0] geo;
  logic [6:0] st, col;
  logic [7:0] con;
  int miscompares = 0, compares = 0;
  initial forever #2 clk = ~clk;
  oled_host_model host_u (.i_clk(clk), .i_settled(stl), .i_discharged(dis), .o_init_n(init_n),
    .o_supply(sup), .o_on(on), .o_off(off));
  oled_power_reset_sequencer #(.SETTLE_CYCLES(8)) dut_u (.I_CLK_SYS(clk), .I_RST(rst),
    .I_CHIP_INIT_LOW_N(init_n), .I_PANEL_HIGH_VOLTAGE_SUPPLY(sup), .i_cmd_display_on(on),
    .i_cmd_display_off(off), .i_cmd_contrast(cc), .i_contrast_val(ctr), .i_cmd_start_line(cs),
    .i_start_line_val(sl), .i_cmd_col_addr(ca), .i_col_addr_val(sl), .i_cmd_remap(cr),
    .i_seg_remap_val(seg), .i_com_scan_val(com), .i_cmd_mode(cm), .i_mode_val(md),
    .o_display_on(dsp), .o_geom_mode(geo), .o_seg_remap(rmp), .o_com_reverse(rev),
    .o_start_line(st), .o_col_addr(col), .o_contrast(con), .o_panel_settled(stl),
    .o_panel_discharged(dis));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic load(input logic [7:0] c, input logic [6:0] v, input logic b, input logic [1:0] m);
    @(posedge clk);
    {cc, cs, ca, cr, cm} <= 5'h1f;
    ctr <= c;
    sl <= v;
    {seg, com} <= {b, b};
    md <= m;
    @(posedge clk);
    {cc, cs, ca, cr, cm} <= 5'h00;
    @(posedge clk) #1;
  endtask
  task automatic defaults(input string m);
    chk({7'h00, dsp}, 8'h00, m);
    chk({6'h00, geo}, {6'h00, MODE_480X128}, m);
    chk({6'h00, rmp, rev}, 8'h00, m);
    chk({1'b0, st}, 8'h00, m);
    chk({1'b0, col}, 8'h00, m);
    chk(con, 8'h7f, m);
  endtask
  task automatic check_loaded();
    load(8'h55, 7'h7f, 1'b1, MODE_ALT);
    chk(con, 8'h55, "contrast load");
    chk({1'b0, st}, 8'h7f, "start load");
    chk({6'h00, rmp, rev}, 8'h03, "map load");
    chk({6'h00, geo}, {6'h00, MODE_ALT}, "mode load");
    chk({1'b0, col}, 8'h7f, "column load");
  endtask
  task automatic check_init_pin();
    host_u.set_init(1'b0);
    load(8'h11, 7'h22, 1'b1, MODE_ALT);
    defaults("init pin defaults");
    host_u.set_init(1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    defaults("reset defaults");
    chk({stl, dis}, 8'h01, "supply flags at reset");
    host_u.up(ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t settle timeout", $time);
      wrap_up();
    end
    @(posedge clk) #1;
    chk({dsp, stl}, 8'h03, "display on after settle");
    check_loaded();
    check_init_pin();
    host_u.down(ok);
    chk({dsp, stl, ok}, 8'h01, "display off and discharged");
    wrap_up();
  end
endmodule
